// >>> design/cit_consts.svh
`ifndef CIT_CONSTS_SVH
`define CIT_CONSTS_SVH
// Interrupt numbers double as latch and mask bit positions
`define CIT_IRQ_HIGH_NUM   5'd11
`define CIT_IRQ_LOW_NUM    5'd22
`define CIT_IRQ_WIDTH      32
`define CIT_CNT_WIDTH      32
// Enable latency in core cycles: start after two, stop after one
`define CIT_START_LAT      2
`define CIT_STOP_LAT       1
// Expiry output pulse length in core cycles
`define CIT_EXP_CYCLES     4'h4
`define CIT_EXP_WIDTH      4
`endif

// >>> design/cit_pkg.sv
package cit_pkg;
  typedef enum logic [1:0] {
    CIT_ST_IDLE,
    CIT_ST_ARM,
    CIT_ST_RUN
  } cit_state_t;
endpackage

// >>> design/cit_irq_latch.sv
`timescale 1ns/1ps
`include "cit_consts.svh"
// Latches both expiry interrupts and picks the highest-priority pending one
module cit_irq_latch (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  // Expiry event
  input  wire logic                       expiry_evt,
  // Software mask and acknowledge
  input  wire logic [`CIT_IRQ_WIDTH-1:0]  irq_mask_reg,
  input  wire logic [`CIT_IRQ_WIDTH-1:0]  irq_ack,
  // Latch state and service request
  output logic      [`CIT_IRQ_WIDTH-1:0]  irq_latch_reg,
  output logic                            irq_req,
  output logic      [4:0]                 irq_num
);
  typedef struct packed {
    logic [`CIT_IRQ_WIDTH-1:0] latch;
    logic                      req;
    logic [4:0]                num;
  } cit_latch_st_t;

  cit_latch_st_t st_r;
  cit_latch_st_t st_nxt;
  logic [`CIT_IRQ_WIDTH-1:0] pend;

  function automatic logic [4:0] lowest_set(input logic [`CIT_IRQ_WIDTH-1:0] v);
    logic [4:0] idx;
    idx = 5'h1F;
    for (int i = `CIT_IRQ_WIDTH - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.latch = st_r.latch & ~irq_ack;
    if (expiry_evt) begin
      st_nxt.latch[`CIT_IRQ_HIGH_NUM] = 1'b1;
      st_nxt.latch[`CIT_IRQ_LOW_NUM]  = 1'b1;
    end
    pend = st_nxt.latch & irq_mask_reg;
    st_nxt.req = |pend;
    st_nxt.num = lowest_set(pend);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign irq_latch_reg = st_r.latch;
  assign irq_req       = st_r.req;
  assign irq_num       = st_r.num;

  property p_latch_both;
    @(posedge sys_clk) disable iff (srst)
      expiry_evt |=> irq_latch_reg[11] && irq_latch_reg[22];
  endproperty
  a_latch_both: assert property (p_latch_both) else $error("expiry not latched twice");

  property p_high_first;
    @(posedge sys_clk) disable iff (srst)
      (irq_latch_reg[11] && irq_mask_reg[11] && irq_latch_reg[22] && irq_mask_reg[22]
       && $stable(irq_latch_reg) && $stable(irq_mask_reg) && !(|irq_latch_reg[10:0]))
      |-> irq_num == 5'd11;
  endproperty
  a_high_first: assert property (p_high_first) else $error("low served before high");
endmodule // cit_irq_latch

// >>> design/cit_core_timer.sv
`timescale 1ns/1ps
`include "cit_consts.svh"
// Function
// - Timer runs while count_run_enable is 1, stopped while 0.
// - While enabled, countdown_value decrements by one each core cycle.
// - Cycle after countdown reaches zero, reload from reload_interval.
// - Expiries spaced reload_interval plus one cycles; interval up to 2^32-1.
// - On zero while enabled, raise interrupt and pulse expiry_output several cycles.
// - Software reads and writes both timer registers.
// - Reading timer registers never disturbs counting or interrupts.
// - Software register write beats reload and decrement.
// - Counting starts two cycles after enable set, stops one after clear.
// - Each expiry latches high interrupt 11 and low interrupt 22.
// - With both unmasked, high one is serviced first.
// - Timer halts while core executes in emulation space.
// - Latch and mask bits sit at their interrupt numbers.
module cit_core_timer #(
  parameter int CNT_W = `CIT_CNT_WIDTH
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  // Universal register transfers
  input  wire logic                       count_wr,
  input  wire logic                       reload_wr,
  input  wire logic [CNT_W-1:0]           ureg_wdata,
  // Mode word bit and core state
  input  wire logic                       count_run_enable,
  input  wire logic                       emu_space,
  // Interrupt mask and acknowledge from the sequencer
  input  wire logic [`CIT_IRQ_WIDTH-1:0]  irq_mask_reg,
  input  wire logic [`CIT_IRQ_WIDTH-1:0]  irq_ack,
  // Register read-back
  output logic      [CNT_W-1:0]           countdown_value,
  output logic      [CNT_W-1:0]           reload_interval,
  // Expiry and interrupt outputs
  output logic                            expiry_output,
  output logic                            expiry_irq_high,
  output logic                            expiry_irq_low,
  output logic      [`CIT_IRQ_WIDTH-1:0]  irq_latch_reg,
  output logic                            irq_req,
  output logic      [4:0]                 irq_num
);
  typedef struct packed {
    logic [CNT_W-1:0]            cnt;
    logic [CNT_W-1:0]            per;
    logic                        run;
    logic                        reload;
    logic [`CIT_EXP_WIDTH-1:0]   exp_cnt;
    logic                        expo;
    logic                        evt;
    cit_pkg::cit_state_t         state;
  } cit_st_t;

  cit_st_t st_r;
  cit_st_t st_nxt;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.evt = 1'b0;
    case (st_r.state)
      cit_pkg::CIT_ST_IDLE: begin
        if (count_run_enable) begin
          st_nxt.state = cit_pkg::CIT_ST_ARM;
        end
      end
      cit_pkg::CIT_ST_ARM: begin
        if (!count_run_enable) begin
          st_nxt.state = cit_pkg::CIT_ST_IDLE;
        end else begin
          st_nxt.state = cit_pkg::CIT_ST_RUN;
        end
      end
      cit_pkg::CIT_ST_RUN: begin
        if (!count_run_enable) begin
          st_nxt.state = cit_pkg::CIT_ST_IDLE;
        end
      end
      default: st_nxt.state = cit_pkg::CIT_ST_IDLE;
    endcase
    st_nxt.run = (st_nxt.state == cit_pkg::CIT_ST_RUN);
    if (st_r.run && !emu_space) begin
      if (st_r.reload) begin
        st_nxt.cnt    = st_r.per;
        st_nxt.reload = 1'b0;
      end else if (st_r.cnt != '0) begin
        st_nxt.cnt = st_r.cnt - 1'b1;
        if (st_r.cnt == CNT_W'(1)) begin
          st_nxt.reload = 1'b1;
          st_nxt.evt    = 1'b1;
        end
      end else begin
        st_nxt.reload = 1'b1;
        st_nxt.evt    = 1'b1;
      end
    end
    if (count_wr) begin
      st_nxt.cnt    = ureg_wdata;
      st_nxt.reload = 1'b0;
    end
    if (reload_wr) begin
      st_nxt.per = ureg_wdata;
    end
    if (st_nxt.evt) begin
      st_nxt.exp_cnt = `CIT_EXP_CYCLES;
    end else if (st_r.exp_cnt != '0) begin
      st_nxt.exp_cnt = st_r.exp_cnt - 1'b1;
    end
    st_nxt.expo = (st_nxt.exp_cnt != '0);
  end

  always_ff @(posedge sys_clk) begin
    st_r.cnt <= st_nxt.cnt;
    st_r.per <= st_nxt.per;
    if (srst) begin
      st_r.run     <= 1'b0;
      st_r.reload  <= 1'b0;
      st_r.exp_cnt <= '0;
      st_r.expo    <= 1'b0;
      st_r.evt     <= 1'b0;
      st_r.state   <= cit_pkg::CIT_ST_IDLE;
    end else begin
      st_r.run     <= st_nxt.run;
      st_r.reload  <= st_nxt.reload;
      st_r.exp_cnt <= st_nxt.exp_cnt;
      st_r.expo    <= st_nxt.expo;
      st_r.evt     <= st_nxt.evt;
      st_r.state   <= st_nxt.state;
    end
  end

  assign countdown_value = st_r.cnt;
  assign reload_interval = st_r.per;
  assign expiry_output   = st_r.expo;
  assign expiry_irq_high = st_r.evt;
  assign expiry_irq_low  = st_r.evt;

  cit_irq_latch u_latch (
    .sys_clk       (sys_clk),
    .srst          (srst),
    .expiry_evt    (st_r.evt),
    .irq_mask_reg  (irq_mask_reg),
    .irq_ack       (irq_ack),
    .irq_latch_reg (irq_latch_reg),
    .irq_req       (irq_req),
    .irq_num       (irq_num)
  );

  sequence s_enable_rise;
    !count_run_enable ##1 count_run_enable [*2];
  endsequence

  property p_start_lat;
    @(posedge sys_clk) disable iff (srst)
      s_enable_rise |-> ##1 st_r.run;
  endproperty
  a_start_lat: assert property (p_start_lat) else $error("start latency wrong");

  property p_stop_lat;
    @(posedge sys_clk) disable iff (srst)
      $fell(count_run_enable) |=> !st_r.run;
  endproperty
  a_stop_lat: assert property (p_stop_lat) else $error("stop latency wrong");

  property p_hold_off;
    @(posedge sys_clk) disable iff (srst)
      (!st_r.run && !count_wr) |=> $stable(countdown_value);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("count moved while stopped");

  property p_dec;
    @(posedge sys_clk) disable iff (srst)
      (st_r.run && !emu_space && !count_wr && !st_r.reload && countdown_value > CNT_W'(1))
      |=> countdown_value == $past(countdown_value) - 1'b1;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement missed");

  property p_reload;
    @(posedge sys_clk) disable iff (srst)
      (st_r.run && !emu_space && st_r.reload && !count_wr)
      |=> countdown_value == $past(reload_interval);
  endproperty
  a_reload: assert property (p_reload) else $error("reload missed");

  property p_exp_pulse;
    @(posedge sys_clk) disable iff (srst)
      expiry_irq_high |-> expiry_output [*4];
  endproperty
  a_exp_pulse: assert property (p_exp_pulse) else $error("expiry pulse short");

  sequence s_last_tick;
    st_r.run && !emu_space && !count_wr && !st_r.reload && countdown_value == CNT_W'(1);
  endsequence

  property p_zero_evt;
    @(posedge sys_clk) disable iff (srst)
      s_last_tick |=> expiry_irq_high && expiry_irq_low && countdown_value == '0;
  endproperty
  a_zero_evt: assert property (p_zero_evt) else $error("expiry missed at zero");

  property p_wr_wins;
    @(posedge sys_clk) disable iff (srst)
      count_wr |=> countdown_value == $past(ureg_wdata);
  endproperty
  a_wr_wins: assert property (p_wr_wins) else $error("write lost");

  property p_emu_halt;
    @(posedge sys_clk) disable iff (srst)
      (emu_space && !count_wr) |=> $stable(countdown_value) && !expiry_irq_high;
  endproperty
  a_emu_halt: assert property (p_emu_halt) else $error("ran in emulation");
endmodule // cit_core_timer

// >>> verification/cit_seq_model.sv
`timescale 1ns/1ps
`include "cit_consts.svh"
// Sequencer stand-in, services one pending number after a delay
module cit_seq_model #(
  parameter int DLY = 3
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  // Service request
  input  wire logic                      irq_req,
  input  wire logic [4:0]                irq_num,
  // Acknowledge
  output logic      [`CIT_IRQ_WIDTH-1:0] irq_ack
);
  int wait_q = 0;

  // take offered number
  // Slow on purpose: request must stand while waiting
  always @(negedge sys_clk) begin
    irq_ack <= '0;
    if (srst || !irq_req) begin
      wait_q <= 0;
    end else if (wait_q == DLY) begin
      irq_ack[irq_num] <= 1'b1;
      wait_q <= 0;
    end else begin
      wait_q <= wait_q + 1;
    end
  end
endmodule // cit_seq_model

// >>> verification/core_interval_timer_test.sv
`timescale 1ns/1ps
module core_interval_timer_test;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        count_wr = 1'b0;
  logic        reload_wr = 1'b0;
  logic        count_run_enable = 1'b0;
  logic        emu_space = 1'b0;
  logic [31:0] ureg_wdata = 32'h0;
  logic [31:0] irq_mask_reg = 32'h0;
  logic [31:0] irq_ack;
  logic [31:0] countdown_value;
  logic [31:0] reload_interval;
  logic [31:0] irq_latch_reg;
  logic        expiry_output;
  logic        expiry_irq_high;
  logic        expiry_irq_low;
  logic        irq_req;
  logic [4:0]  irq_num;
  logic [31:0] v;
  int          n_errors = 0;
  int          compares = 0;
  int          cnt;
  // Period, high unmask, low unmask, first number serviced
  localparam logic [38:0] ROWS [3] = '{{32'h1, 1'h1, 1'h1, 5'h0B},
    {32'h3, 1'h0, 1'h1, 5'h16}, {32'h6, 1'h1, 1'h0, 5'h0B}};

  always #12.5 sys_clk = ~sys_clk;

  cit_core_timer dut (
    .sys_clk(sys_clk), .srst(srst), .count_wr(count_wr), .reload_wr(reload_wr),
    .ureg_wdata(ureg_wdata), .count_run_enable(count_run_enable),
    .emu_space(emu_space), .irq_mask_reg(irq_mask_reg), .irq_ack(irq_ack),
    .countdown_value(countdown_value), .reload_interval(reload_interval),
    .expiry_output(expiry_output), .expiry_irq_high(expiry_irq_high),
    .expiry_irq_low(expiry_irq_low), .irq_latch_reg(irq_latch_reg),
    .irq_req(irq_req), .irq_num(irq_num));

  cit_seq_model #(.DLY(3)) seq (
    .sys_clk(sys_clk), .srst(srst), .irq_req(irq_req), .irq_num(irq_num),
    .irq_ack(irq_ack));

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test;
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One write cycle; sel high picks the reload register
  task automatic wr(input logic sel, input logic [31:0] d);
    count_wr = !sel;
    reload_wr = sel;
    ureg_wdata = d;
    cyc(1);
    count_wr = 1'b0;
    reload_wr = 1'b0;
  endtask

  task automatic wait_exp;
    cnt = 0;
    while (expiry_irq_high !== 1'b1 && cnt < 5000) begin
      cnt++;
      cyc(1);
    end
    if (cnt == 5000) begin
      chk("expiry wait", 32'h0, 32'h1);
      stop_test;
    end
  endtask

  initial begin
    cyc(8);
    chk("reset outs", {expiry_output, expiry_irq_high, expiry_irq_low, irq_req, irq_num}, 32'h0);
    chk("reset latch", irq_latch_reg, 32'h0);
    srst = 1'b0;
    // Count is unreset, give it a value
    wr(1'b0, 32'h0);
    for (int r = 0; r < 3; r++) begin
      count_run_enable = 1'b0;
      v = ROWS[r][38:7];
      irq_mask_reg = {9'h0, ROWS[r][5], 10'h0, ROWS[r][6], 11'h0};
      cyc(2);
      wr(1'b0, v);
      cyc(1);
      wr(1'b1, v);
      count_run_enable = 1'b1;
      wait_exp;
      chk("count at expiry", countdown_value, 32'h0);
      chk("expiry pins", {expiry_output, expiry_irq_low}, 32'h3);
      cyc(1);
      chk("latch bits", {irq_latch_reg[22], irq_latch_reg[11]}, 32'h3);
      cyc(1);
      chk("first serviced", {irq_req, irq_num}, {1'h1, ROWS[r][4:0]});
      cnt = 2;
      while (expiry_irq_high !== 1'b1 && cnt < 99) begin
        cnt++;
        cyc(1);
      end
      chk("expiry spacing", 32'(cnt), v + 32'h1);
    end
    // Enable latency and stop
    count_run_enable = 1'b0;
    cyc(2);
    wr(1'b0, 32'h5);
    cyc(1);
    wr(1'b1, 32'h5);
    count_run_enable = 1'b1;
    cyc(2);
    chk("start hold", countdown_value, 32'h5);
    cyc(1);
    chk("started", countdown_value, 32'h4);
    v = countdown_value;
    cyc(1);
    chk("decrement", countdown_value, v - 32'h1);
    count_run_enable = 1'b0;
    cyc(1);
    chk("stop latency", countdown_value, 32'h2);
    cyc(1);
    v = countdown_value;
    cyc(3);
    chk("stopped", countdown_value, v);
    // Emulation halt
    wr(1'b0, 32'h40);
    cyc(1);
    wr(1'b1, 32'h40);
    count_run_enable = 1'b1;
    cyc(4);
    emu_space = 1'b1;
    cyc(2);
    v = countdown_value;
    cyc(3);
    chk("emulation halt", countdown_value, v);
    emu_space = 1'b0;
    cyc(3);
    chk("resumed", countdown_value, v - 32'h3);
    // Writes while running, widest interval
    wr(1'b1, 32'hFFFFFFFF);
    chk("reload write", reload_interval, 32'hFFFFFFFF);
    cyc(1);
    wr(1'b0, 32'h3);
    chk("count write", countdown_value, 32'h3);
    wait_exp;
    cyc(1);
    chk("reload max", countdown_value, 32'hFFFFFFFF);
    wr(1'b1, 32'h9);
    chk("write priority", reload_interval, 32'h9);
    chk("decrement max", countdown_value, 32'hFFFFFFFE);
    // Reset mid-run keeps the count
    srst = 1'b1;
    cyc(2);
    v = countdown_value;
    chk("reset run outs", {expiry_output, expiry_irq_high, irq_req, irq_num}, 32'h0);
    chk("reset run latch", irq_latch_reg, 32'h0);
    cyc(2);
    chk("reset hold", countdown_value, v);
    srst = 1'b0;
    cyc(2);
    chk("restart hold", countdown_value, v);
    cyc(1);
    chk("restart", countdown_value, v - 32'h1);
    stop_test;
  end
endmodule // core_interval_timer_test
